// >>> rtl/xar_pkg.sv
// Shared constants and types for the analog control read-back block
package xar_pkg;
    localparam int XAR_VOD_W = 3;
    localparam int XAR_PRE_W = 5;
    localparam int XAR_EQ_W = 4;
    localparam int XAR_DCG_W = 2;
    localparam int XAR_NUM_CH = 4;
    localparam int XAR_ADDR_W = 2;
    // DC gain codes
    localparam logic [1:0] XAR_DCG_0DB = 2'h0;
    localparam logic [1:0] XAR_DCG_3DB = 2'h1;
    localparam logic [1:0] XAR_DCG_6DB = 2'h2;
    localparam logic [1:0] XAR_DCG_BAD = 2'h3;
    // Reset values of the held settings
    localparam logic [2:0] XAR_VOD_RST = 3'h0;
    localparam logic [4:0] XAR_PRE_RST = 5'h00;
    localparam logic [3:0] XAR_EQ_RST = 4'h0;
    localparam logic [1:0] XAR_DCG_RST = 2'h0;

    typedef struct packed {
        logic [XAR_VOD_W-1:0] vod;
        logic [XAR_PRE_W-1:0] pre;
        logic [XAR_EQ_W-1:0] eq;
        logic [XAR_DCG_W-1:0] dcg;
    } xar_set_type;

    localparam xar_set_type XAR_SET_RST = '{vod: XAR_VOD_RST, pre: XAR_PRE_RST, eq: XAR_EQ_RST, dcg: XAR_DCG_RST};

    function automatic logic xar_dcg_legal(input logic [XAR_DCG_W-1:0] code);
        xar_dcg_legal = (code != XAR_DCG_BAD);
    endfunction : xar_dcg_legal
endpackage : xar_pkg

// >>> rtl/xar_store_if.sv
// Carrier between the controller and its per-channel setting store
`timescale 1ns/1ps
interface xar_store_if #(parameter int NUM_CH = 4);
    import xar_pkg::*;
    logic [NUM_CH-1:0] wr_mask;
    xar_set_type wr_data [NUM_CH];
    xar_set_type cur [NUM_CH];
    modport ctrl (output wr_mask, output wr_data, input cur);
    modport store (input wr_mask, input wr_data, output cur);
endinterface : xar_store_if

// >>> rtl/xar_setting_store.sv
// Per-channel held analog settings
`timescale 1ns/1ps
module xar_setting_store #(
    parameter int NUM_CH = 4
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic rstn, // Async reset, active low
    xar_store_if.store st // Write side and contents
);
    import xar_pkg::*;

    xar_set_type bank [NUM_CH];

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < NUM_CH; c++) begin
                bank[c] <= XAR_SET_RST;
            end
        end else begin
            for (int c = 0; c < NUM_CH; c++) begin
                if (st.wr_mask[c]) begin
                    bank[c] <= st.wr_data[c];
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            st.cur[c] = bank[c];
        end
    end
endmodule : xar_setting_store

// >>> rtl/xar_analog_ctrl.sv
// Analog control write path and per-channel read-back outputs
// Function
// - DC gain codes 0,1,2 mean 0,3,6 dB; code 3 is illegal.
// - DC gain input is 2 bits in shared or common mode, else 2 bits per channel.
// - Swing read-back shows the last stored swing of the selected channel.
// - Pre-emphasis read-back shows the value last written to the selected channel.
// - Equalizer read-back returns the current channel equalization setting.
// - DC gain read-back returns the current gain in the same encoding.
// - Read-back widths follow channel count and shared or common mode.
`timescale 1ns/1ps
module xar_analog_ctrl #(
    parameter int NUM_CH = xar_pkg::XAR_NUM_CH,
    parameter int ADDR_W = xar_pkg::XAR_ADDR_W,
    parameter bit SHARED_ADDR = 1'b0,
    parameter bit COMMON_CTRL = 1'b0,
    localparam int LANES = (SHARED_ADDR || COMMON_CTRL) ? 1 : NUM_CH
) (
    input wire logic ref_clk, // 20 MHz clock
    input wire logic rstn, // Async reset, active low
    input wire logic wr_strobe, // Write the presented settings
    input wire logic rd_strobe, // Read-back request (shared address mode)
    input wire logic [ADDR_W-1:0] logical_channel_address, // Addressed channel
    input wire logic [xar_pkg::XAR_VOD_W*LANES-1:0] tx_vodctrl, // Output swing write
    input wire logic [xar_pkg::XAR_PRE_W*LANES-1:0] tx_preemp, // Pre-emphasis write
    input wire logic [xar_pkg::XAR_EQ_W*LANES-1:0] rx_eqctrl, // Equalizer write
    input wire logic [xar_pkg::XAR_DCG_W*LANES-1:0] rx_eqdcgain, // DC gain write
    output logic [xar_pkg::XAR_VOD_W*LANES-1:0] tx_vodctrl_out, // Output swing read-back
    output logic [xar_pkg::XAR_PRE_W*LANES-1:0] tx_preemp_out, // Pre-emphasis read-back
    output logic [xar_pkg::XAR_EQ_W*LANES-1:0] rx_eqctrl_out, // Equalizer read-back
    output logic [xar_pkg::XAR_DCG_W*LANES-1:0] rx_eqdcgain_out, // DC gain read-back
    output logic readback_valid // One-cycle pulse after a shared read
);
    import xar_pkg::*;

    xar_store_if #(.NUM_CH(NUM_CH)) st ();

    xar_setting_store #(.NUM_CH(NUM_CH)) u_store (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .st(st.store)
    );

    function automatic xar_set_type lane_of(input int l, input logic [XAR_VOD_W*LANES-1:0] v,
                                            input logic [XAR_PRE_W*LANES-1:0] p,
                                            input logic [XAR_EQ_W*LANES-1:0] e,
                                            input logic [XAR_DCG_W*LANES-1:0] d);
        xar_set_type s;
        s.vod = v[l*XAR_VOD_W +: XAR_VOD_W];
        s.pre = p[l*XAR_PRE_W +: XAR_PRE_W];
        s.eq = e[l*XAR_EQ_W +: XAR_EQ_W];
        s.dcg = d[l*XAR_DCG_W +: XAR_DCG_W];
        lane_of = s;
    endfunction : lane_of

    function automatic logic addr_hits(input logic [ADDR_W-1:0] a, input int c);
        addr_hits = (int'(a) == c);
    endfunction : addr_hits

    ////////////////////////////////////////////////////////////////////////////
    // Write path
    // Illegal gain keeps the old code; nothing tells the user it was dropped
    // channel lane selection
    always_comb begin
        for (int c = 0; c < NUM_CH; c++) begin
            xar_set_type w;
            w = lane_of((SHARED_ADDR || COMMON_CTRL) ? 0 : c, tx_vodctrl, tx_preemp, rx_eqctrl, rx_eqdcgain);
            if (!xar_dcg_legal(w.dcg)) begin
                w.dcg = st.cur[c].dcg;
            end
            st.wr_data[c] = w;
            st.wr_mask[c] = wr_strobe && (!SHARED_ADDR || addr_hits(logical_channel_address, c));
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read-back
    // Out-of-range address reads channel 0 rather than X
    xar_set_type rd_pick;
    always_comb begin
        rd_pick = st.cur[0];
        for (int c = 0; c < NUM_CH; c++) begin
            if (addr_hits(logical_channel_address, c)) begin
                rd_pick = st.cur[c];
            end
        end
    end

    // lane-sized outputs
    // Shared mode holds its last read until the next read strobe
    // held swing shown
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_vodctrl_out <= {LANES{XAR_VOD_RST}};
        end else if (SHARED_ADDR) begin
            if (rd_strobe) begin
                tx_vodctrl_out[XAR_VOD_W-1:0] <= rd_pick.vod;
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                tx_vodctrl_out[l*XAR_VOD_W +: XAR_VOD_W] <= st.cur[l].vod;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tx_preemp_out <= {LANES{XAR_PRE_RST}};
        end else if (SHARED_ADDR) begin
            if (rd_strobe) begin
                tx_preemp_out[XAR_PRE_W-1:0] <= rd_pick.pre;
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                tx_preemp_out[l*XAR_PRE_W +: XAR_PRE_W] <= st.cur[l].pre;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_eqctrl_out <= {LANES{XAR_EQ_RST}};
        end else if (SHARED_ADDR) begin
            if (rd_strobe) begin
                rx_eqctrl_out[XAR_EQ_W-1:0] <= rd_pick.eq;
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                rx_eqctrl_out[l*XAR_EQ_W +: XAR_EQ_W] <= st.cur[l].eq;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rx_eqdcgain_out <= {LANES{XAR_DCG_RST}};
        end else if (SHARED_ADDR) begin
            if (rd_strobe) begin
                rx_eqdcgain_out[XAR_DCG_W-1:0] <= rd_pick.dcg;
            end
        end else begin
            for (int l = 0; l < LANES; l++) begin
                rx_eqdcgain_out[l*XAR_DCG_W +: XAR_DCG_W] <= st.cur[l].dcg;
            end
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            readback_valid <= 1'b0;
        end else begin
            readback_valid <= SHARED_ADDR && rd_strobe;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    // Lane 0 write checks hold in every mode; top-lane checks reach channel LANES-1, the far one only with per-channel lanes
    logic ch0_sel;
    assign ch0_sel = !SHARED_ADDR || addr_hits(logical_channel_address, 0);

    AST_DCG_BAD_KEPT: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_strobe && ch0_sel && rx_eqdcgain[XAR_DCG_W-1:0] == XAR_DCG_BAD) |=> $stable(st.cur[0].dcg))
        else $error("illegal DC gain code was stored");
    AST_DCG_GOOD_TAKEN: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_strobe && ch0_sel && rx_eqdcgain[XAR_DCG_W-1:0] != XAR_DCG_BAD)
        |=> st.cur[0].dcg == $past(rx_eqdcgain[XAR_DCG_W-1:0]))
        else $error("legal DC gain code not stored");
    AST_LANE_TOP_WRITE: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_strobe && !SHARED_ADDR && xar_dcg_legal(rx_eqdcgain[(LANES-1)*XAR_DCG_W +: XAR_DCG_W]))
        |=> st.cur[LANES-1].dcg == $past(rx_eqdcgain[(LANES-1)*XAR_DCG_W +: XAR_DCG_W]))
        else $error("top gain lane not stored in its channel");
    AST_COMMON_SAME: assert property (@(posedge ref_clk) disable iff (!rstn)
        (wr_strobe && COMMON_CTRL && !SHARED_ADDR) |=> st.cur[NUM_CH-1].vod == $past(tx_vodctrl[XAR_VOD_W-1:0]))
        else $error("common control did not reach every channel");

    AST_VOD_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!SHARED_ADDR && wr_strobe) ##1 !wr_strobe |=> tx_vodctrl_out[XAR_VOD_W-1:0] == $past(tx_vodctrl[XAR_VOD_W-1:0], 2))
        else $error("swing read-back does not show last write");
    AST_PRE_FOLLOWS: assert property (@(posedge ref_clk) disable iff (!rstn)
        (!SHARED_ADDR && wr_strobe) |=> ##1 tx_preemp_out[XAR_PRE_W-1:0] == $past(tx_preemp[XAR_PRE_W-1:0], 2))
        else $error("pre-emphasis read-back does not show last write");
    AST_EQ_CURRENT: assert property (@(posedge ref_clk) disable iff (!rstn)
        !SHARED_ADDR |=> rx_eqctrl_out[XAR_EQ_W-1:0] == $past(st.cur[0].eq))
        else $error("equalizer read-back stale");
    AST_DCG_CURRENT: assert property (@(posedge ref_clk) disable iff (!rstn)
        !SHARED_ADDR |=> rx_eqdcgain_out[XAR_DCG_W-1:0] == $past(st.cur[0].dcg))
        else $error("DC gain read-back stale");
    AST_LANE_TOP_OUT: assert property (@(posedge ref_clk) disable iff (!rstn)
        !SHARED_ADDR |=> rx_eqctrl_out[(LANES-1)*XAR_EQ_W +: XAR_EQ_W] == $past(st.cur[LANES-1].eq))
        else $error("top equalizer lane read-back stale");
    AST_DCG_OUT_LEGAL: assert property (@(posedge ref_clk) disable iff (!rstn)
        xar_dcg_legal(rx_eqdcgain_out[XAR_DCG_W-1:0]))
        else $error("gain read-back shows the illegal code");

    AST_SHARED_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
        (SHARED_ADDR && rd_strobe) |=> readback_valid && rx_eqctrl_out[XAR_EQ_W-1:0] == $past(rd_pick.eq)
        && tx_vodctrl_out[XAR_VOD_W-1:0] == $past(rd_pick.vod))
        else $error("shared read-back not from addressed channel");
    AST_SHARED_HOLD: assert property (@(posedge ref_clk) disable iff (!rstn)
        (SHARED_ADDR && !rd_strobe) |=> $stable(tx_preemp_out) && !readback_valid)
        else $error("shared read-back changed without a read");
    AST_SHARED_OTHER_KEPT: assert property (@(posedge ref_clk) disable iff (!rstn)
        (SHARED_ADDR && wr_strobe && !addr_hits(logical_channel_address, 0)) |=> $stable(st.cur[0]))
        else $error("shared write disturbed an unaddressed channel");
    AST_SHARED_DCG_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
        (SHARED_ADDR && rd_strobe) |=> rx_eqdcgain_out[XAR_DCG_W-1:0] == $past(rd_pick.dcg))
        else $error("shared gain read-back not from addressed channel");
    AST_VALID_AFTER_READ: assert property (@(posedge ref_clk) disable iff (!rstn)
        readback_valid |-> SHARED_ADDR && $past(rd_strobe))
        else $error("read-back valid without a preceding read");
    AST_VALID_NONSHARED: assert property (@(posedge ref_clk) disable iff (!rstn)
        !SHARED_ADDR |-> !readback_valid)
        else $error("read-back valid pulsed outside shared mode");

    COV_WRITE: cover property (@(posedge ref_clk) disable iff (!rstn) wr_strobe ##2 1'b1);
    COV_BAD_GAIN: cover property (@(posedge ref_clk) disable iff (!rstn)
        wr_strobe && rx_eqdcgain[XAR_DCG_W-1:0] == XAR_DCG_BAD);
    COV_READ: cover property (@(posedge ref_clk) disable iff (!rstn) wr_strobe ##[1:4] rd_strobe);
    COV_SHARED_VALID: cover property (@(posedge ref_clk) disable iff (!rstn) readback_valid);
    COV_BACK_TO_BACK: cover property (@(posedge ref_clk) disable iff (!rstn) wr_strobe ##1 wr_strobe);
endmodule : xar_analog_ctrl

// >>> tb/xar_user_model.sv
// Far-side user logic model that drives the write controls
`timescale 1ns/1ps
module xar_user_model (
    input wire logic ref_clk, // 20 MHz clock
    output logic wr_strobe, // Write request
    output logic [11:0] vod, // Swing lanes
    output logic [19:0] pre, // Pre-emphasis lanes
    output logic [15:0] eq, // Equalizer lanes
    output logic [7:0] dcg // DC gain lanes
);
    initial begin
        wr_strobe = 1'b0;
        vod = 12'h000;
        pre = 20'h00000;
        eq = 16'h0000;
        dcg = 8'h00;
    end
    // legal codes unless a test asks otherwise
    task automatic do_write(input logic [11:0] v, input logic [19:0] p, input logic [15:0] e, input logic [7:0] d);
        @(negedge ref_clk);
        vod = v;
        pre = p;
        eq = e;
        dcg = d;
        wr_strobe = 1'b1;
        @(negedge ref_clk);
        wr_strobe = 1'b0;
        // Scramble data so a late sample shows up as a mismatch
        vod = ~v;
        pre = ~p;
        eq = ~e;
        dcg = ~d;
    endtask : do_write
endmodule : xar_user_model

// >>> tb/tb_top.sv
// Self-checking bench for the analog control read-back block
`timescale 1ns/1ps
module tb_top;
    import xar_pkg::*;
    logic ref_clk;
    logic rstn;
    logic rd_strobe;
    logic wr_strobe;
    logic [11:0] vod, vod_o;
    logic [19:0] pre, pre_o;
    logic [15:0] eq, eq_o;
    logic [7:0] dcg, dcg_o;
    logic rb_valid;
    logic [1:0] addr;
    logic [2:0] vod_s_o, vod_c_o;
    logic [4:0] pre_s_o, pre_c_o;
    logic [3:0] eq_s_o, eq_c_o;
    logic [1:0] dcg_s_o, dcg_c_o;
    logic rb_valid_s;
    int mismatches = 0;
    int total_checks = 0;
    xar_user_model model_u (.ref_clk(ref_clk), .wr_strobe(wr_strobe), .vod(vod), .pre(pre), .eq(eq), .dcg(dcg));
    xar_analog_ctrl dut_u (.ref_clk(ref_clk), .rstn(rstn), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe),
        .logical_channel_address(2'h3), .tx_vodctrl(vod), .tx_preemp(pre), .rx_eqctrl(eq), .rx_eqdcgain(dcg),
        .tx_vodctrl_out(vod_o), .tx_preemp_out(pre_o), .rx_eqctrl_out(eq_o), .rx_eqdcgain_out(dcg_o),
        .readback_valid(rb_valid));
    // Shared-address variant: one lane, channel picked by addr
    xar_analog_ctrl #(.SHARED_ADDR(1'b1)) dut_sh_u (.ref_clk(ref_clk), .rstn(rstn), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .logical_channel_address(addr), .tx_vodctrl(vod[2:0]), .tx_preemp(pre[4:0]),
        .rx_eqctrl(eq[3:0]), .rx_eqdcgain(dcg[1:0]), .tx_vodctrl_out(vod_s_o), .tx_preemp_out(pre_s_o),
        .rx_eqctrl_out(eq_s_o), .rx_eqdcgain_out(dcg_s_o), .readback_valid(rb_valid_s));
    // Common-control variant: lane 0 feeds every channel
    xar_analog_ctrl #(.COMMON_CTRL(1'b1)) dut_cm_u (.ref_clk(ref_clk), .rstn(rstn), .wr_strobe(wr_strobe),
        .rd_strobe(rd_strobe), .logical_channel_address(2'h0), .tx_vodctrl(vod[2:0]), .tx_preemp(pre[4:0]),
        .rx_eqctrl(eq[3:0]), .rx_eqdcgain(dcg[1:0]), .tx_vodctrl_out(vod_c_o), .tx_preemp_out(pre_c_o),
        .rx_eqctrl_out(eq_c_o), .rx_eqdcgain_out(dcg_c_o), .readback_valid());
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task automatic check_all(input logic [11:0] v, input logic [19:0] p, input logic [15:0] e, input logic [7:0] d);
        @(negedge ref_clk);
        check("swing", {20'h0, vod_o}, {20'h0, v});
        check("preemp", {12'h0, pre_o}, {12'h0, p});
        check("eq", {16'h0, eq_o}, {16'h0, e});
        check("dcgain", {24'h0, dcg_o}, {24'h0, d});
        check("valid", {31'h0, rb_valid}, 32'h0);
    endtask : check_all
    task automatic stop_test;
        if (mismatches == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    ////////////////////////////////////////////////////////////////
    // Reset contents and per-lane widths
    task automatic test_reset;
        check_all(12'h000, 20'h00000, 16'h0000, 8'h00);
        check("dcg width", $bits(dcg), XAR_DCG_W * XAR_NUM_CH);
        check("out width", $bits(vod_o) + $bits(pre_o) + $bits(eq_o), (XAR_VOD_W + XAR_PRE_W + XAR_EQ_W) * XAR_NUM_CH);
    endtask : test_reset
    // Own value per lane, some lanes repeated; read strobe ignored here
    task automatic test_lanes;
        rd_strobe = 1'b1;
        model_u.do_write(12'hA51, 20'h1F3C2, 16'h7451, {XAR_DCG_6DB, XAR_DCG_3DB, XAR_DCG_0DB, XAR_DCG_6DB});
        check_all(12'hA51, 20'h1F3C2, 16'h7451, 8'h92);
        rd_strobe = 1'b0;
    endtask : test_lanes
    // Every legal gain code on all lanes
    task automatic test_codes;
        for (int c = 0; c < 3; c++) begin
            model_u.do_write(12'h123, 20'h0ABCD, 16'h0101, {4{c[1:0]}});
            check_all(12'h123, 20'h0ABCD, 16'h0101, {4{c[1:0]}});
            check("cm swing", {29'h0, vod_c_o}, 32'h3);
            check("cm preemp", {27'h0, pre_c_o}, 32'hD);
            check("cm eq", {28'h0, eq_c_o}, 32'h1);
            check("cm dcgain", {30'h0, dcg_c_o}, {30'h0, c[1:0]});
        end
    endtask : test_codes
    // Illegal gain code keeps old gain while the rest update
    task automatic test_illegal;
        model_u.do_write(12'h5D2, 20'hE0017, 16'h4575, {4{XAR_DCG_BAD}});
        check_all(12'h5D2, 20'hE0017, 16'h4575, {4{XAR_DCG_6DB}});
        check("cm dcgain", {30'h0, dcg_c_o}, {30'h0, XAR_DCG_6DB});
    endtask : test_illegal
    // Shared address: a write lands only in the addressed channel
    task automatic shared_write(input logic [1:0] a, input logic [2:0] v, input logic [4:0] p,
                                input logic [3:0] e, input logic [1:0] d);
        addr = a;
        model_u.do_write({9'h000, v}, {15'h0000, p}, {12'h000, e}, {6'h00, d});
    endtask : shared_write
    // Shared read: result and valid one cycle on, equalizer result held afterwards
    task automatic shared_read(input logic [1:0] a, input logic [2:0] v, input logic [4:0] p,
                               input logic [3:0] e, input logic [1:0] d);
        @(negedge ref_clk);
        addr = a;
        rd_strobe = 1'b1;
        @(negedge ref_clk);
        rd_strobe = 1'b0;
        addr = ~a;
        check("sh valid", {31'h0, rb_valid_s}, 32'h1);
        check("sh swing", {29'h0, vod_s_o}, {29'h0, v});
        check("sh preemp", {27'h0, pre_s_o}, {27'h0, p});
        check("sh eq", {28'h0, eq_s_o}, {28'h0, e});
        check("sh dcgain", {30'h0, dcg_s_o}, {30'h0, d});
        @(negedge ref_clk);
        check("sh valid end", {31'h0, rb_valid_s}, 32'h0);
        check("sh eq held", {28'h0, eq_s_o}, {28'h0, e});
    endtask : shared_read
    task automatic test_shared;
        shared_write(2'h0, 3'h5, 5'h13, 4'h7, XAR_DCG_3DB);
        shared_write(2'h1, 3'h2, 5'h0C, 4'h1, XAR_DCG_6DB);
        shared_write(2'h2, 3'h7, 5'h1E, 4'h4, XAR_DCG_0DB);
        shared_write(2'h3, 3'h1, 5'h05, 4'h5, XAR_DCG_6DB);
        shared_write(2'h3, 3'h6, 5'h09, 4'h2, XAR_DCG_BAD);
        shared_read(2'h2, 3'h7, 5'h1E, 4'h4, XAR_DCG_0DB);
        shared_read(2'h0, 3'h5, 5'h13, 4'h7, XAR_DCG_3DB);
        shared_read(2'h3, 3'h6, 5'h09, 4'h2, XAR_DCG_6DB);
        shared_read(2'h1, 3'h2, 5'h0C, 4'h1, XAR_DCG_6DB);
    endtask : test_shared
    ////////////////////////////////////////////////////////////////
    initial begin
        rstn = 1'b0;
        rd_strobe = 1'b0;
        addr = 2'h0;
        repeat (12) @(posedge ref_clk);
        @(negedge ref_clk);
        rstn = 1'b1;
        test_reset();
        test_lanes();
        test_codes();
        test_illegal();
        test_shared();
        stop_test();
    end
    // Hang guard well beyond the few dozen cycles needed
    initial begin
        #100000;
        mismatches++;
        stop_test();
    end
endmodule : tb_top
